/* verilog/uart_flags_pkg.sv */
// Shared constants and state encodings for the serial transceiver
package uart_flags_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ      = 25_000_000;
  localparam int unsigned BAUD_RATE   = 115_200;
  // Whole cycles per bit; rounding down keeps the rate slightly fast, within tolerance
  localparam int unsigned BIT_CYCLES  = CLK_HZ / BAUD_RATE;
  localparam int unsigned HALF_BIT    = BIT_CYCLES / 2;
  localparam int unsigned CNT_W       = 9;

  // ==========================================================================
  // Frame layout
  localparam int unsigned DATA_BITS   = 8;
  localparam int unsigned FRAME_BITS  = 10;
  localparam int unsigned WORD_W      = 9;   // Data plus its framing error bit
  localparam int unsigned FRAME_ERROR_FLAG_POS    = 8;

  // ==========================================================================
  // Receive buffer and flow control
  localparam int unsigned RX_DEPTH    = 2;
  localparam int unsigned RX_CNT_W    = 2;
  localparam logic [1:0]  PAUSE_LEVEL = 2'h1;  // Fill level that asks the sender to stop
  localparam logic [7:0]  CHAR_XOFF   = 8'h13;
  localparam logic [7:0]  CHAR_XON    = 8'h11;

  // ==========================================================================
  // Reset values
  localparam logic        LINE_IDLE   = 1'b1;
  localparam logic        TX_EMPTY_RST = 1'b1;

  // ==========================================================================
  // State encodings
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_BUSY = 1'b1
  } tx_state_t;

endpackage

/* verilog/sync_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2,
  parameter int unsigned CNT_W = 2
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready,
  // Fill level
  output logic [CNT_W-1:0]      count
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t next_r;
  logic        push;
  logic        pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Honest full and empty straight from the fill level
  assign in_ready  = (r.count != CNT_W'(DEPTH));
  assign out_valid = (r.count != '0);
  assign out_data  = r.mem[r.rd_ptr];
  assign count     = r.count;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and level update
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr_ptr] = in_data;
      next_r.wr_ptr        = bump(r.wr_ptr);
    end
    if (pop) begin
      next_r.rd_ptr = bump(r.rd_ptr);
    end
    next_r.count = r.count + CNT_W'(push) - CNT_W'(pop);
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule
`default_nettype wire

/* verilog/uart_flags.sv */
// Serial transceiver with two-entry receive buffer, error flags and flow control
`timescale 1ns/1ps
`default_nettype none
module uart_flags (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  // Serial line
  input  wire logic       rx_pin,
  output logic            tx_pin,
  // Hardware flow control, low means go
  input  wire logic       cts_b,
  output logic            rts_b,
  // Configuration
  input  wire logic       continuous_rx_enable,
  input  wire logic       rx_irq_enable,
  input  wire logic       tx_irq_enable,
  input  wire logic       hw_flow_enable,
  input  wire logic       sw_flow_enable,
  // Receive side
  input  wire logic       rx_read,
  output logic [7:0]      rx_data_reg,
  output logic            rx_available_flag,
  output logic            frame_error_flag,
  output logic            overrun_error_flag,
  // Transmit side
  input  wire logic       tx_write,
  input  wire logic [7:0] tx_wdata,
  output logic            tx_empty_flag,
  // Interrupt requests
  output logic            irq_rx,
  output logic            irq_tx
);

  localparam int unsigned CW = uart_flags_pkg::CNT_W;

  typedef struct packed {
    logic                      rx_meta;
    logic                      rx_sync;
    logic                      rx_last;
    logic                      cts_meta;
    logic                      cts_sync;
    uart_flags_pkg::rx_state_t rx_st;
    logic [CW-1:0]             rx_cnt;
    logic [2:0]                rx_bits;
    logic [7:0]                rx_shift;
    logic                      push_valid;
    logic [8:0]                push_word;
    logic                      overrun_error_flag;
    logic [7:0]                rx_data_reg;
    logic                      frame_error_flag;
    logic                      rx_available_flag;
    logic                      irq_rx;
    logic                      paused;
    logic                      xoff_sent;
    logic                      xoff_req;
    logic                      xon_req;
    logic                      rts_b;
    logic [7:0]                tx_hold;
    logic                      tx_full;
    logic                      tx_empty_flag;
    logic                      irq_tx;
    uart_flags_pkg::tx_state_t tx_st;
    logic [CW-1:0]             tx_cnt;
    logic [3:0]                tx_bits;
    logic [9:0]                tx_shift;
    logic                      tx_pin;
  } state_t;

  state_t     r;
  state_t     next_r;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic [1:0] fifo_count;
  logic       fifo_pop;
  logic       rx_frame_end;
  logic       rx_accept;

  // ==========================================================================
  // Helpers
  function automatic logic bit_end(input logic [CW-1:0] cnt);
    bit_end = (cnt == CW'(uart_flags_pkg::BIT_CYCLES - 1));
  endfunction

  function automatic logic [9:0] frame_of(input logic [7:0] data);
    frame_of = {uart_flags_pkg::LINE_IDLE, data, 1'b0};
  endfunction

  // ==========================================================================
  // Receive buffer
  // Reads pop the head directly; stays readable after an overrun
  assign fifo_pop     = rx_read && fifo_out_valid;
  assign rx_frame_end = (r.rx_st == uart_flags_pkg::RX_STOP) && bit_end(r.rx_cnt);
  assign rx_accept    = continuous_rx_enable && !r.overrun_error_flag;

  sync_fifo #(
    .WIDTH (uart_flags_pkg::WORD_W),
    .DEPTH (uart_flags_pkg::RX_DEPTH),
    .CNT_W (uart_flags_pkg::RX_CNT_W)
  ) u_rx_fifo (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .in_valid  (r.push_valid),
    .in_data   (r.push_word),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_pop),
    .count     (fifo_count)
  );

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_r            = r;
    next_r.push_valid = 1'b0;
    // Two-stage synchronisers; the second stage feeds logic, plus rx_last, its delayed copy, for the start edge
    next_r.rx_meta  = rx_pin;
    next_r.rx_sync  = r.rx_meta;
    next_r.rx_last  = r.rx_sync;
    next_r.cts_meta = cts_b;
    next_r.cts_sync = r.cts_meta;

    // Receiver: returns to idle mid stop bit so the next start edge is never missed
    next_r.rx_cnt = r.rx_cnt + 1'b1;
    case (r.rx_st)
      uart_flags_pkg::RX_IDLE: begin
        next_r.rx_cnt = '0;
        if (rx_accept && r.rx_last && !r.rx_sync) begin
          next_r.rx_st = uart_flags_pkg::RX_START;
        end
      end
      uart_flags_pkg::RX_START: begin
        if (r.rx_cnt == CW'(uart_flags_pkg::HALF_BIT - 1)) begin
          next_r.rx_cnt  = '0;
          next_r.rx_bits = '0;
          next_r.rx_st   = r.rx_sync ? uart_flags_pkg::RX_IDLE : uart_flags_pkg::RX_DATA;
        end
      end
      uart_flags_pkg::RX_DATA: begin
        if (bit_end(r.rx_cnt)) begin
          next_r.rx_cnt   = '0;
          next_r.rx_shift = {r.rx_sync, r.rx_shift[7:1]};
          next_r.rx_bits  = r.rx_bits + 1'b1;
          if (r.rx_bits == 3'h7) begin
            next_r.rx_st = uart_flags_pkg::RX_STOP;
          end
        end
      end
      uart_flags_pkg::RX_STOP: begin
        if (rx_frame_end) begin
          next_r.rx_st = uart_flags_pkg::RX_IDLE;
          if (rx_accept) begin
            if (fifo_in_ready) begin
              next_r.push_valid = 1'b1;
              next_r.push_word  = {!r.rx_sync, r.rx_shift};
            end else begin
              next_r.overrun_error_flag = 1'b1;
            end
            if (sw_flow_enable && r.rx_shift == uart_flags_pkg::CHAR_XOFF) begin
              next_r.paused = 1'b1;
            end else if (sw_flow_enable && r.rx_shift == uart_flags_pkg::CHAR_XON) begin
              next_r.paused = 1'b0;
            end
          end
        end
      end
      default: next_r.rx_st = uart_flags_pkg::RX_IDLE;
    endcase
    // Receive enable low holds the receiver in reset and releases the lock
    if (!continuous_rx_enable) begin
      next_r.rx_st              = uart_flags_pkg::RX_IDLE;
      next_r.overrun_error_flag = 1'b0;
    end
    if (!sw_flow_enable) begin
      next_r.paused    = 1'b0;
      next_r.xoff_sent = 1'b0;
    end

    // Visible receive status follows the buffer head, regardless of continuous_rx_enable; irq_rx also needs rx_irq_enable
    next_r.rx_data_reg       = fifo_out_data[7:0];
    next_r.frame_error_flag  = fifo_out_data[uart_flags_pkg::FRAME_ERROR_FLAG_POS];
    next_r.rx_available_flag = fifo_out_valid;
    next_r.irq_rx            = fifo_out_valid && rx_irq_enable;

    // Flow control toward the sender, asked early since the buffer is tiny
    next_r.rts_b = hw_flow_enable && (fifo_count >= uart_flags_pkg::PAUSE_LEVEL);
    if (sw_flow_enable && !r.xoff_sent && fifo_count >= uart_flags_pkg::PAUSE_LEVEL) begin
      next_r.xoff_req  = 1'b1;
      next_r.xoff_sent = 1'b1;
    end else if (sw_flow_enable && r.xoff_sent && fifo_count == '0) begin
      next_r.xon_req   = 1'b1;
      next_r.xoff_sent = 1'b0;
    end

    // Transmitter: flow characters go ahead of queued data
    next_r.tx_cnt = r.tx_cnt + 1'b1;
    case (r.tx_st)
      uart_flags_pkg::TX_IDLE: begin
        next_r.tx_cnt  = '0;
        next_r.tx_bits = '0;
        if (r.xoff_req) begin
          next_r.xoff_req = 1'b0;
          next_r.tx_shift = frame_of(uart_flags_pkg::CHAR_XOFF);
          next_r.tx_pin   = 1'b0;
          next_r.tx_st    = uart_flags_pkg::TX_BUSY;
        end else if (r.xon_req) begin
          next_r.xon_req  = 1'b0;
          next_r.tx_shift = frame_of(uart_flags_pkg::CHAR_XON);
          next_r.tx_pin   = 1'b0;
          next_r.tx_st    = uart_flags_pkg::TX_BUSY;
        end else if (r.tx_full && !(hw_flow_enable && r.cts_sync) && !r.paused) begin
          next_r.tx_full  = 1'b0;
          next_r.tx_shift = frame_of(r.tx_hold);
          next_r.tx_pin   = 1'b0;
          next_r.tx_st    = uart_flags_pkg::TX_BUSY;
        end
      end
      uart_flags_pkg::TX_BUSY: begin
        if (bit_end(r.tx_cnt)) begin
          next_r.tx_cnt   = '0;
          next_r.tx_bits  = r.tx_bits + 1'b1;
          next_r.tx_shift = {uart_flags_pkg::LINE_IDLE, r.tx_shift[9:1]};
          next_r.tx_pin   = r.tx_shift[1];
          if (r.tx_bits == 4'(uart_flags_pkg::FRAME_BITS - 1)) begin
            next_r.tx_pin = uart_flags_pkg::LINE_IDLE;
            next_r.tx_st  = uart_flags_pkg::TX_IDLE;
          end
        end
      end
      default: next_r.tx_st = uart_flags_pkg::TX_IDLE;
    endcase
    // A write wins over the move into the shifter in the same cycle
    if (tx_write) begin
      next_r.tx_hold = tx_wdata;
      next_r.tx_full = 1'b1;
    end
    next_r.tx_empty_flag = !next_r.tx_full;
    next_r.irq_tx        = !next_r.tx_full && tx_irq_enable;
  end

  // ==========================================================================
  // State register; line outputs rest high
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      r               <= '0;
      r.rx_meta       <= uart_flags_pkg::LINE_IDLE;
      r.rx_sync       <= uart_flags_pkg::LINE_IDLE;
      r.rx_last       <= uart_flags_pkg::LINE_IDLE;
      r.tx_pin        <= uart_flags_pkg::LINE_IDLE;
      r.tx_empty_flag <= uart_flags_pkg::TX_EMPTY_RST;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign tx_pin             = r.tx_pin;
  assign rts_b              = r.rts_b;
  assign rx_data_reg        = r.rx_data_reg;
  assign rx_available_flag  = r.rx_available_flag;
  assign frame_error_flag   = r.frame_error_flag;
  assign overrun_error_flag = r.overrun_error_flag;
  assign tx_empty_flag      = r.tx_empty_flag;
  assign irq_rx             = r.irq_rx;
  assign irq_tx             = r.irq_tx;

  // ==========================================================================
  // Checks
  property p_overrun_set;
    @(posedge ref_clk) disable iff (!rst_b)
    rx_frame_end && rx_accept && !fifo_in_ready |=> overrun_error_flag && !r.push_valid;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged");

  property p_locked;
    @(posedge ref_clk) disable iff (!rst_b)
    overrun_error_flag |-> r.rx_st == uart_flags_pkg::RX_IDLE || !continuous_rx_enable
      ##1 !r.push_valid;
  endproperty
  a_locked: assert property (p_locked) else $error("byte taken while locked");

  property p_keep;
    @(posedge ref_clk) disable iff (!rst_b)
    overrun_error_flag && !rx_read |=> fifo_count == $past(fifo_count);
  endproperty
  a_keep: assert property (p_keep) else $error("held bytes changed after overrun");

  property p_avail;
    @(posedge ref_clk) disable iff (!rst_b)
    ##1 rx_available_flag == $past(fifo_count != 2'h0);
  endproperty
  a_avail: assert property (p_avail) else $error("available flag wrong");

  property p_read_more;
    @(posedge ref_clk) disable iff (!rst_b)
    rx_read && fifo_count == 2'h2 |=> rx_available_flag [*2];
  endproperty
  a_read_more: assert property (p_read_more) else $error("flag dropped with data left");

  property p_tx_write;
    @(posedge ref_clk) disable iff (!rst_b)
    tx_write |=> !tx_empty_flag;
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("empty flag after write");

  property p_tx_irq;
    @(posedge ref_clk) disable iff (!rst_b)
    tx_empty_flag && tx_irq_enable && !tx_write |=> irq_tx;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("transmit request missing");

  property p_gate;
    @(posedge ref_clk) disable iff (!rst_b)
    !tx_irq_enable && !rx_irq_enable |=> !irq_tx && !irq_rx;
  endproperty
  a_gate: assert property (p_gate) else $error("request without enable");

  property p_frame_error_flag;
    @(posedge ref_clk) disable iff (!rst_b)
    fifo_out_valid |=> frame_error_flag == $past(fifo_out_data[8]);
  endproperty
  a_frame_error_flag: assert property (p_frame_error_flag) else $error("frame flag not from head");

  property p_overrun_error_flag_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    !continuous_rx_enable |=> !overrun_error_flag;
  endproperty
  a_overrun_error_flag_clear: assert property (p_overrun_error_flag_clear) else $error("overrun kept");

endmodule
`default_nettype wire

/* verif/remote_station.sv */
// Behavioural remote serial station on the far side of the transceiver's line pins
`timescale 1ns/1ps
`default_nettype none
module remote_station (
  // Clock
  input  wire logic ref_clk,
  // Serial line as seen from the station
  input  wire logic line_in,
  output var logic  line_out,
  // Hardware flow control
  input  wire logic rts_b,
  output var logic  cts_b,
  input  wire logic hw_mode
);
  localparam int unsigned BIT = uart_flags_pkg::BIT_CYCLES;

  logic [7:0] got [$];  // Bytes heard from the transceiver
  logic       paused;   // Set while the transceiver has asked us to stop
  logic [7:0] sh;

  // Idle line, and clear to send by default
  initial begin
    line_out = 1'b1;
    cts_b    = 1'b0;
    paused   = 1'b0;
  end

  // ==================
  // Listener
  // Samples each bit in its middle, LSB first; pause characters act at once
  initial begin
    forever begin
      @(negedge line_in);
      repeat (BIT + BIT / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
        sh[i] = line_in;
        repeat (BIT) @(posedge ref_clk);
      end
      got.push_back(sh);
      if (sh == uart_flags_pkg::CHAR_XOFF) paused = 1'b1;
      if (sh == uart_flags_pkg::CHAR_XON) paused = 1'b0;
    end
  end

  // ==================
  // Sender
  // Flow characters skip the pause, or a paused pair could never recover
  task automatic send_byte(input logic [7:0] d, input logic stop);
    logic [9:0] fr;
    fr = {stop, d, 1'b0};
    @(posedge ref_clk);
    while ((hw_mode && rts_b) || (paused && d != uart_flags_pkg::CHAR_XON
           && d != uart_flags_pkg::CHAR_XOFF))
      @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      line_out <= fr[i];
      repeat (BIT) @(posedge ref_clk);
    end
    line_out <= 1'b1;
    if (!stop) repeat (BIT) @(posedge ref_clk); // Idle bit so a new start edge exists
  endtask
endmodule
`default_nettype wire

/* verif/test_uart_flags.sv */
// Self-checking bench for the serial transceiver and its status flags
`timescale 1ns/1ps
`default_nettype none
module test_uart_flags;
  // Clock, reset and design inputs
  logic       ref_clk;
  logic       rst_b;
  logic       continuous_rx_enable;
  logic       rx_irq_enable;
  logic       tx_irq_enable;
  logic       hw_flow_enable;
  logic       sw_flow_enable;
  logic       rx_read;
  logic       tx_write;
  logic [7:0] tx_wdata;
  // Line wires and design outputs
  logic       rx_pin;
  logic       tx_pin;
  logic       cts_b;
  logic       rts_b;
  logic [7:0] rx_data_reg;
  logic       rx_available_flag;
  logic       frame_error_flag;
  logic       overrun_error_flag;
  logic       tx_empty_flag;
  logic       irq_rx;
  logic       irq_tx;
  int         errors;
  int         n_compared;

  uart_flags u_uart_flags (.ref_clk, .rst_b, .rx_pin, .tx_pin, .cts_b, .rts_b,
    .continuous_rx_enable, .rx_irq_enable, .tx_irq_enable, .hw_flow_enable,
    .sw_flow_enable, .rx_read, .rx_data_reg, .rx_available_flag, .frame_error_flag,
    .overrun_error_flag, .tx_write, .tx_wdata, .tx_empty_flag, .irq_rx, .irq_tx);

  remote_station u_remote_station (.ref_clk, .line_in(tx_pin), .line_out(rx_pin),
    .rts_b, .cts_b, .hw_mode(hw_flow_enable));

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ==================
  // Helpers
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Pop pulse, then two edges so the lagging outputs settle
  task automatic do_read;
    @(posedge ref_clk) rx_read <= 1'b1;
    @(posedge ref_clk) rx_read <= 1'b0;
    cyc(2);
    #1;
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk);
    tx_wdata <= d;
    tx_write <= 1'b1;
    @(posedge ref_clk) tx_write <= 1'b0;
    #1;
  endtask

  task automatic wait_avail;
    for (int i = 0; i < 3000 && rx_available_flag !== 1'b1; i++) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_q(input int n);
    for (int i = 0; i < 6000 && u_remote_station.got.size() < n; i++) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic seen(input logic [7:0] b);
    foreach (u_remote_station.got[i]) if (u_remote_station.got[i] === b) return 1'b1;
    return 1'b0;
  endfunction

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==================
  // Scenarios
  task automatic t_reset;
    @(posedge ref_clk);
    #1;
    chk("tx_pin", 8'h01, 8'(tx_pin));
    chk("tx_empty", 8'h01, 8'(tx_empty_flag));
    chk("rx_avail", 8'h00, 8'(rx_available_flag));
    chk("overrun", 8'h00, 8'(overrun_error_flag));
    $display("done reset");
  endtask

  // Three back to back bytes with the receive request masked
  task automatic t_rx_overrun;
    @(posedge ref_clk) continuous_rx_enable <= 1'b1;
    cyc(4);
    u_remote_station.send_byte(8'hA5, 1'b1);
    #1;
    chk("rx_avail", 8'h01, 8'(rx_available_flag));
    chk("irq_rx masked", 8'h00, 8'(irq_rx));
    u_remote_station.send_byte(8'h3C, 1'b0);
    u_remote_station.send_byte(8'h96, 1'b1);
    #1;
    chk("overrun", 8'h01, 8'(overrun_error_flag));
    chk("head", 8'hA5, rx_data_reg);
    chk("frame_error_flag head", 8'h00, 8'(frame_error_flag));
    @(posedge ref_clk) rx_irq_enable <= 1'b1;
    cyc(2);
    #1;
    chk("irq_rx", 8'h01, 8'(irq_rx));
    do_read();
    chk("second", 8'h3C, rx_data_reg);
    chk("rx_avail left", 8'h01, 8'(rx_available_flag));
    chk("frame_error_flag second", 8'h01, 8'(frame_error_flag));
    chk("overrun kept", 8'h01, 8'(overrun_error_flag));
    do_read();
    chk("rx_avail empty", 8'h00, 8'(rx_available_flag));
    chk("irq_rx empty", 8'h00, 8'(irq_rx));
    u_remote_station.send_byte(8'h5A, 1'b1);
    #1;
    chk("locked", 8'h00, 8'(rx_available_flag));
    @(posedge ref_clk) continuous_rx_enable <= 1'b0;
    cyc(2);
    #1;
    chk("overrun clear", 8'h00, 8'(overrun_error_flag));
    @(posedge ref_clk) continuous_rx_enable <= 1'b1;
    cyc(2);
    u_remote_station.send_byte(8'hC3, 1'b1);
    #1;
    chk("relock data", 8'hC3, rx_data_reg);
    chk("frame_error_flag clean", 8'h00, 8'(frame_error_flag));
    do_read();
    $display("done rx overrun");
  endtask

  // Request enable while empty, then a write while the shifter is busy
  task automatic t_tx;
    u_remote_station.got.delete();
    chk("irq_tx off", 8'h00, 8'(irq_tx));
    @(posedge ref_clk) tx_irq_enable <= 1'b1;
    cyc(2);
    #1;
    chk("irq_tx on", 8'h01, 8'(irq_tx));
    wr(8'h4B);
    chk("empty after wr", 8'h00, 8'(tx_empty_flag));
    cyc(3);
    #1;
    chk("empty after load", 8'h01, 8'(tx_empty_flag));
    wr(8'hD2);
    cyc(300);
    #1;
    chk("held full", 8'h00, 8'(tx_empty_flag));
    chk("irq_tx full", 8'h00, 8'(irq_tx));
    chk("irq_rx quiet", 8'h00, 8'(irq_rx));
    wait_q(2);
    chk("tx byte 0", 8'h4B, u_remote_station.got[0]);
    chk("tx byte 1", 8'hD2, u_remote_station.got[1]);
    chk("irq_tx again", 8'h01, 8'(irq_tx));
    @(posedge ref_clk) tx_irq_enable <= 1'b0;
    cyc(2);
    #1;
    chk("irq_tx gated", 8'h00, 8'(irq_tx));
    chk("flag stays", 8'h01, 8'(tx_empty_flag));
    $display("done tx");
  endtask

  task automatic t_hw_flow;
    u_remote_station.got.delete();
    @(posedge ref_clk);
    hw_flow_enable <= 1'b1;
    u_remote_station.cts_b <= 1'b1;
    wr(8'h69);
    cyc(3000);
    #1;
    chk("cts held", 8'h00, 8'(u_remote_station.got.size()));
    chk("cts full", 8'h00, 8'(tx_empty_flag));
    @(posedge ref_clk) u_remote_station.cts_b <= 1'b0;
    wait_q(1);
    chk("cts go", 8'h69, u_remote_station.got[0]);
    u_remote_station.send_byte(8'h77, 1'b1);
    #1;
    chk("rts up", 8'h01, 8'(rts_b));
    fork
      u_remote_station.send_byte(8'h78, 1'b1);
    join_none
    cyc(2500);
    #1;
    chk("rts holds", 8'h77, rx_data_reg);
    do_read();
    wait_avail();
    chk("rts release", 8'h78, rx_data_reg);
    // The forked sender still owns the line for the rest of its stop bit
    wait fork;
    do_read();
    chk("rts down", 8'h00, 8'(rts_b));
    @(posedge ref_clk) hw_flow_enable <= 1'b0;
    $display("done hw flow");
  endtask

  task automatic t_sw_flow;
    u_remote_station.got.delete();
    @(posedge ref_clk) sw_flow_enable <= 1'b1;
    u_remote_station.send_byte(8'h41, 1'b1);
    wait_q(1);
    chk("xoff sent", 8'h13, u_remote_station.got[0]);
    do_read();
    wait_q(2);
    chk("xon sent", 8'h11, u_remote_station.got[1]);
    u_remote_station.send_byte(uart_flags_pkg::CHAR_XOFF, 1'b1);
    wait_avail();
    do_read();
    wr(8'h5A);
    cyc(3000);
    #1;
    chk("paused", 8'h00, 8'(seen(8'h5A)));
    u_remote_station.send_byte(uart_flags_pkg::CHAR_XON, 1'b1);
    wait_avail();
    do_read();
    for (int i = 0; i < 8000 && !seen(8'h5A); i++) @(posedge ref_clk);
    chk("resumed", 8'h01, 8'(seen(8'h5A)));
    @(posedge ref_clk) sw_flow_enable <= 1'b0;
    $display("done sw flow");
  endtask

  // ==================
  // Main sequence and watchdog
  initial begin
    rst_b = 1'b0;
    continuous_rx_enable = 1'b0;
    rx_irq_enable = 1'b0;
    tx_irq_enable = 1'b0;
    hw_flow_enable = 1'b0;
    sw_flow_enable = 1'b0;
    rx_read = 1'b0;
    tx_write = 1'b0;
    tx_wdata = 8'h00;
    errors = 0;
    n_compared = 0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_rx_overrun();
    t_tx();
    t_hw_flow();
    t_sw_flow();
    summarize();
  end

  // All scenarios need roughly fifty thousand cycles
  initial begin
    repeat (95000) @(posedge ref_clk);
    errors++;
    $display("[ERR] watchdog expected done seen hang");
    summarize();
  end
endmodule
`default_nettype wire
